// ---- rtl/pulse_speed_consts.vh ----
// Constants for the pulse train speed input block.
`ifndef PULSE_SPEED_CONSTS_VH
`define PULSE_SPEED_CONSTS_VH

// Clock period of mclk in nanoseconds.
`define CLK_PERIOD_NS 20
// Measurement window in microseconds.
`define WINDOW_TIME_US 16600
// Measurement window in clock cycles: 16.6 ms at a 20 ns clock period.
`define WINDOW_CYCLES 20'hcaa30
// Width of the window counter.
`define WINDOW_CNT_W 20

// Division ratio values: disabled, largest accepted.
`define RATIO_OFF 8'h00
`define RATIO_MAX 8'hfa
// Maximum pulse rate per unit of division ratio, in pulses per second.
`define RATE_PER_RATIO 400
// Each received pulse is counted this many times.
`define COUNT_MULT 2
`define COUNT_STEP 3'h2
// Fixed point scale applied to the window count before comparing with full scale.
`define FRAC_SCALE 100
`define FRAC_SCALE_W 7'h64
// Full scale count per unit of ratio, scaled by FRAC_SCALE (400 * 2 * 16.6 ms * 100).
`define FS_PER_RATIO 11'h530
// Highest permitted input rate in pulses per second.
`define MAX_PULSE_RATE 100000
// Largest doubled count that a legal input gives in one window.
`define MAX_WINDOW_COUNT (((`MAX_PULSE_RATE / 1000) * `COUNT_MULT * `WINDOW_TIME_US) / 1000)

// Speed units: the maximum-input speed is in 1 r/min, the command in 0.1 r/min.
`define SPEED_SCALE 5'ha
`define SPEED_LIMIT 16'h8ca0
`define SPEED_ZERO 16'h0000

// Divider geometry.
`define DIV_NUM_W 35
`define DIV_DEN_W 19
`define DIV_STEPS 6'h23

`endif

// ---- rtl/pulse_train_speed_input.v ----
// Pulse train to speed command converter with windowed rate measurement.
`timescale 1ns/1ps
`include "pulse_speed_consts.vh"
module pulse_train_speed_input #(
    parameter [`WINDOW_CNT_W-1:0] WINDOW_CYCLES = `WINDOW_CYCLES
) (
    input wire mclk,
    input wire resetn,
    input wire pulse_input_a,
    input wire pulse_input_b,
    input wire [7:0] pulse_division_ratio,
    input wire [15:0] zero_input_speed,
    input wire [11:0] max_input_speed,
    input wire start,
    input wire preset_select,
    input wire [15:0] preset_speed,
    input wire [15:0] base_speed,
    output reg [15:0] speed_command,
    output reg pulse_mode_active,
    output reg speed_update,
    output reg rate_overrange,
    output reg [15:0] measured_count
);
    // Pin synchronisers; the first stage feeds only the second.
    reg a_meta;
    reg a_sync;
    reg a_prev;
    reg b_meta;
    reg b_sync;
    reg b_prev;
    wire a_edge;
    wire b_edge;
    wire [2:0] edge_add;

    // Window timing and pulse accumulation.
    reg [`WINDOW_CNT_W-1:0] window_cnt;
    reg [15:0] pulse_count;
    reg [16:0] next_pulse_sum;
    reg [15:0] next_pulse_count;
    wire window_end;

    // Settings and results captured at the window end.
    reg [7:0] ratio_cfg;
    reg [15:0] zero_cfg;
    reg [15:0] max_cfg;
    reg [15:0] win_count;
    reg [1:0] state;
    localparam [1:0] ST_MEASURE = 2'b00;
    localparam [1:0] ST_CALC = 2'b01;
    localparam [1:0] ST_DIVIDE = 2'b10;
    localparam [1:0] ST_APPLY = 2'b11;
    reg ramp_up;
    reg [15:0] pulse_speed;
    reg [`DIV_NUM_W-1:0] div_num;
    reg [`DIV_DEN_W-1:0] div_den;
    reg div_start;
    wire [`DIV_NUM_W-1:0] div_quot;
    wire div_done;

    // Combinational scaling terms.
    reg [`DIV_DEN_W-1:0] full_scale;
    reg [22:0] scaled_count;
    reg [`DIV_DEN_W-1:0] frac;
    reg [15:0] span;
    reg next_overrange;
    reg [15:0] next_speed_command;

    assign a_edge = a_sync & ~a_prev;
    assign b_edge = b_sync & ~b_prev;
    assign edge_add = (a_edge ? `COUNT_STEP : 3'h0) + (b_edge ? `COUNT_STEP : 3'h0);
    assign window_end = (window_cnt == WINDOW_CYCLES - {{(`WINDOW_CNT_W-1){1'b0}}, 1'b1});

    always @(posedge mclk) begin
        if (!resetn) begin
            a_meta <= 1'b0;
            a_sync <= 1'b0;
            a_prev <= 1'b0;
            b_meta <= 1'b0;
            b_sync <= 1'b0;
            b_prev <= 1'b0;
        end else begin
            a_meta <= pulse_input_a;
            a_sync <= a_meta;
            a_prev <= a_sync;
            b_meta <= pulse_input_b;
            b_sync <= b_meta;
            b_prev <= b_sync;
        end
    end

    // Saturating accumulation of doubled pulses from both inputs.
    always @* begin
        next_pulse_sum = {1'b0, (window_end ? 16'h0000 : pulse_count)} + {14'h0000, edge_add};
        next_pulse_count = next_pulse_sum[16] ? 16'hffff : next_pulse_sum[15:0];
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            window_cnt <= {`WINDOW_CNT_W{1'b0}};
            pulse_count <= 16'h0000;
        end else begin
            window_cnt <= window_end ? {`WINDOW_CNT_W{1'b0}} :
                window_cnt + {{(`WINDOW_CNT_W-1){1'b0}}, 1'b1};
            pulse_count <= next_pulse_count;
        end
    end

    // Scaling: the full scale count is ratio * 400 pps * 2 * window, scaled by 100.
    always @* begin
        full_scale = {11'h000, ratio_cfg} * {8'h00, `FS_PER_RATIO};
        scaled_count = {7'h00, win_count} * {16'h0000, `FRAC_SCALE_W};
        next_overrange = scaled_count > {4'h0, full_scale};
        frac = next_overrange ? full_scale : scaled_count[`DIV_DEN_W-1:0];
        span = ramp_up ? (max_cfg - zero_cfg) : (zero_cfg - max_cfg);
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            state <= ST_MEASURE;
            ratio_cfg <= `RATIO_OFF;
            zero_cfg <= `SPEED_ZERO;
            max_cfg <= `SPEED_ZERO;
            win_count <= 16'h0000;
            ramp_up <= 1'b1;
            pulse_speed <= `SPEED_ZERO;
            div_num <= {`DIV_NUM_W{1'b0}};
            div_den <= {`DIV_DEN_W{1'b0}};
            div_start <= 1'b0;
            rate_overrange <= 1'b0;
            measured_count <= 16'h0000;
            speed_update <= 1'b0;
            pulse_mode_active <= 1'b0;
        end else begin
            div_start <= 1'b0;
            speed_update <= 1'b0;
            case (state)
                ST_MEASURE: begin
                    if (window_end) begin
                        // Ratios above the top of the range act as the top value.
                        ratio_cfg <= (pulse_division_ratio > `RATIO_MAX) ?
                            `RATIO_MAX : pulse_division_ratio;
                        zero_cfg <= (zero_input_speed > `SPEED_LIMIT) ?
                            `SPEED_LIMIT : zero_input_speed;
                        max_cfg <= {4'h0, max_input_speed} * {11'h000, `SPEED_SCALE};
                        win_count <= pulse_count;
                        measured_count <= pulse_count;
                        state <= ST_CALC;
                    end
                end
                ST_CALC: begin
                    ramp_up <= max_cfg >= zero_cfg;
                    pulse_mode_active <= ratio_cfg != `RATIO_OFF;
                    if (ratio_cfg == `RATIO_OFF) begin
                        // Speed settings play no part while the input is disabled.
                        pulse_speed <= `SPEED_ZERO;
                        rate_overrange <= 1'b0;
                        state <= ST_MEASURE;
                    end else begin
                        state <= ST_DIVIDE;
                    end
                end
                ST_DIVIDE: begin
                    // The span uses ramp_up settled in the previous state.
                    div_num <= {19'h00000, span} * {16'h0000, frac};
                    div_den <= full_scale;
                    rate_overrange <= next_overrange;
                    div_start <= 1'b1;
                    state <= ST_APPLY;
                end
                ST_APPLY: begin
                    if (div_done) begin
                        pulse_speed <= ramp_up ? zero_cfg + div_quot[15:0] :
                            zero_cfg - div_quot[15:0];
                        speed_update <= 1'b1;
                        state <= ST_MEASURE;
                    end
                end
                default: begin
                    state <= ST_MEASURE;
                end
            endcase
        end
    end

    serial_divider divider (
        .mclk(mclk),
        .resetn(resetn),
        .start(div_start),
        .dividend(div_num),
        .divisor(div_den),
        .quotient(div_quot),
        .done(div_done)
    );

    // Command selection: pulse mode overrides presets, start gates the output.
    always @* begin
        if (!start) begin
            next_speed_command = `SPEED_ZERO;
        end else if (pulse_mode_active) begin
            next_speed_command = pulse_speed;
        end else if (preset_select) begin
            next_speed_command = preset_speed;
        end else begin
            next_speed_command = base_speed;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            speed_command <= `SPEED_ZERO;
        end else begin
            speed_command <= next_speed_command;
        end
    end
endmodule

// ---- rtl/serial_divider.v ----
// Unsigned restoring divider producing one quotient bit per clock.
`timescale 1ns/1ps
`include "pulse_speed_consts.vh"
module serial_divider (
    input wire mclk,
    input wire resetn,
    input wire start,
    input wire [`DIV_NUM_W-1:0] dividend,
    input wire [`DIV_DEN_W-1:0] divisor,
    output reg [`DIV_NUM_W-1:0] quotient,
    output reg done
);
    reg [`DIV_DEN_W:0] remainder;
    reg [`DIV_DEN_W-1:0] den;
    reg [5:0] steps_left;
    reg busy;
    wire [`DIV_DEN_W:0] shifted;
    wire fits;

    assign shifted = {remainder[`DIV_DEN_W-1:0], quotient[`DIV_NUM_W-1]};
    assign fits = shifted >= {1'b0, den};

    always @(posedge mclk) begin
        if (!resetn) begin
            remainder <= {(`DIV_DEN_W+1){1'b0}};
            den <= {`DIV_DEN_W{1'b0}};
            quotient <= {`DIV_NUM_W{1'b0}};
            steps_left <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                remainder <= {(`DIV_DEN_W+1){1'b0}};
                den <= divisor;
                quotient <= dividend;
                steps_left <= `DIV_STEPS;
                busy <= 1'b1;
            end else if (busy) begin
                remainder <= fits ? (shifted - {1'b0, den}) : shifted;
                quotient <= {quotient[`DIV_NUM_W-2:0], fits};
                steps_left <= steps_left - 6'h01;
                if (steps_left == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- verification/pulse_source.sv ----
// Open-collector pulse source model driving the two pulse pins.
`timescale 1ns/1ps
module pulse_source (
    input wire mclk,
    output reg pin_a,
    output reg pin_b
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // Sends n pulses of 500 cycles each, which is 100 kpps at 50 MHz.
    task send(input integer n, input reg use_b);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(negedge mclk);
                pin_a = !use_b;
                pin_b = use_b;
                repeat (250) @(negedge mclk);
                pin_a = 1'b0;
                pin_b = 1'b0;
                repeat (249) @(negedge mclk);
            end
        end
    endtask
endmodule

// ---- verification/pulse_speed_checker.sv ----
// Concurrent checks on the ports of the pulse train speed input block.
`timescale 1ns/1ps
module pulse_speed_checker #(
    parameter [19:0] WINDOW_CYCLES = 20'h01388
) (
    input wire mclk,
    input wire resetn,
    input wire start,
    input wire preset_select,
    input wire [15:0] base_speed,
    input wire [15:0] speed_command,
    input wire pulse_mode_active,
    input wire speed_update,
    input wire rate_overrange,
    input wire [15:0] measured_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    reg [19:0] gap;
    always @(posedge mclk) begin
        if (!resetn || speed_update) begin
            gap <= 20'h00000;
        end else if (gap != 20'hfffff) begin
            gap <= gap + 20'h00001;
        end
    end
    a_update_single: assert property (speed_update |=> !speed_update)
        else $error("speed update longer than one cycle");
    a_update_spacing: assert property (speed_update |-> gap >= WINDOW_CYCLES - 20'h00001)
        else $error("two speed updates within one window");
    a_update_needs_mode: assert property (speed_update |-> pulse_mode_active)
        else $error("speed update while pulse mode is off");
    a_update_after_mode: assert property ($rose(pulse_mode_active) |-> ##[30:50] speed_update)
        else $error("no speed update after pulse mode began");
    a_overrange_cleared: assert property ($fell(pulse_mode_active) |-> ##[0:2] !rate_overrange)
        else $error("overrange kept with ratio zero");
    a_count_even: assert property (measured_count != 16'hffff |-> !measured_count[0])
        else $error("odd pulse count");
    a_stop_zero: assert property (!start |=> speed_command == 16'h0000)
        else $error("command not zero without start");
    a_base_when_off: assert property (
        (start && !pulse_mode_active && !preset_select) ##1 (!pulse_mode_active && $past(resetn))
        |-> speed_command == $past(base_speed))
        else $error("command is not the base speed");
    a_preset_ignored: assert property (
        (pulse_mode_active && start && !speed_update)[*3] |-> $stable(speed_command))
        else $error("command moved without a speed update");
endmodule
bind pulse_train_speed_input pulse_speed_checker #(.WINDOW_CYCLES(WINDOW_CYCLES)) chk (
    .mclk(mclk), .resetn(resetn), .start(start), .preset_select(preset_select),
    .base_speed(base_speed), .speed_command(speed_command),
    .pulse_mode_active(pulse_mode_active), .speed_update(speed_update),
    .rate_overrange(rate_overrange), .measured_count(measured_count));

// ---- verification/test_pulse_train_speed_input.sv ----
// Self-checking bench for the pulse train speed input block.
`timescale 1ns/1ps
module test_pulse_train_speed_input;
    localparam integer W = 5000;
    reg mclk = 1'b0;
    reg resetn = 1'b0;
    reg start = 1'b0;
    reg preset_select = 1'b0;
    reg [7:0] ratio = 8'h00;
    reg [15:0] zero = 16'h0000;
    reg [11:0] maxs = 12'h000;
    reg [15:0] preset = 16'h0000;
    reg [15:0] base = 16'h0000;
    reg [31:0] seed = 32'h37e57481;
    reg [32:0] noteq[$];
    reg [32:0] note;
    wire pin_a, pin_b, mode, upd, ovr;
    wire [15:0] cmd, cnt;
    integer n_mismatch = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer i, n;
    pulse_source src (.mclk(mclk), .pin_a(pin_a), .pin_b(pin_b));
    pulse_train_speed_input #(.WINDOW_CYCLES(20'h01388)) dut (.mclk(mclk), .resetn(resetn),
        .pulse_input_a(pin_a), .pulse_input_b(pin_b), .pulse_division_ratio(ratio),
        .zero_input_speed(zero), .max_input_speed(maxs), .start(start),
        .preset_select(preset_select), .preset_speed(preset), .base_speed(base),
        .speed_command(cmd), .pulse_mode_active(mode), .speed_update(upd),
        .rate_overrange(ovr), .measured_count(cnt));
    always #10 mclk = ~mclk;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [32:0] expect_of(input [7:0] r, input [15:0] z, input [11:0] m, input integer c);
        longint fs, fr, mx, zz;
        begin
            zz = z;
            mx = m * 10;
            fs = ((r > 8'hfa) ? 250 : r) * 1328;
            fr = (c * 200 > fs) ? fs : c * 200;
            expect_of[32] = (c * 200 > fs);
            expect_of[31:16] = c * 2;
            expect_of[15:0] = (mx >= zz) ? zz + (mx - zz) * fr / fs : zz - (zz - mx) * fr / fs;
        end
    endfunction
    task check(input [32:0] got, input [32:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 80000) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    always @(negedge mclk) begin
        if (upd === 1'b1) begin
            note = noteq.pop_front();
            repeat (2) @(negedge mclk);
            check({ovr, cnt, cmd}, note);
        end
    end
    initial begin
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        start = 1'b1;
        base = 16'h04d2;
        for (i = 0; i < 8; i = i + 1) begin
            repeat (5) @(negedge mclk);
            if (i == 0) begin
                check({32'h0, mode}, 33'h0);
            end
            seed = lfsr(seed);
            ratio = (i % 4 == 3) ? 8'hff : (i % 4 == 2) ? 8'hfa : seed[1:0] + 8'h01;
            zero = seed[31:16] % 16'h8ca1;
            maxs = seed[15:4] % 12'he11;
            preset_select = seed[2];
            preset = seed[23:8];
            n = (i == 0) ? 0 : seed[11:8] % 10;
            noteq.push_back(expect_of(ratio, zero, maxs, n));
            src.send(n, seed[3]);
            repeat (W - 5 - n * 500) @(negedge mclk);
        end
        $display("test pulse windows done");
        repeat (5) @(negedge mclk);
        ratio = 8'h00;
        preset_select = 1'b0;
        src.send(3, 1'b1);
        repeat (W - 1500 + 10) @(negedge mclk);
        check({32'h0, mode}, 33'h0);
        check({17'h0, cmd}, {17'h0, base});
        preset_select = 1'b1;
        repeat (2) @(negedge mclk);
        check({17'h0, cmd}, {17'h0, preset});
        start = 1'b0;
        repeat (2) @(negedge mclk);
        check({17'h0, cmd}, 33'h0);
        check({32'h0, noteq.size() != 0}, 33'h0);
        $display("test ratio zero done");
        complete_run;
    end
endmodule
